// File: reset_standby_ctrl.sv
// Purpose: Reset sequence timing, restart on higher resets, standby handshake
// Assumes: 40 MHz clk; power-on reset and supply-good come from the PMIC
// Notes: Sequence duration counts the maximum time; done pulses at the end
`default_nettype none
module reset_standby_ctrl
    import rst_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic power_on_reset_n,
    input wire logic reset_pin_n,
    input wire logic supply_good_in,
    input wire logic functional_reset_req,
    input wire logic destructive_reset_req,
    input wire logic standby_enter,
    input wire logic standby_exit,
    output logic in_reset,
    output rst_seq_pkg::reset_kind_type reset_kind,
    output logic reset_done,
    output logic standby_power_request_n,
    output logic standby_domains_ready
);
    import rst_seq_pkg::*;

    typedef enum {ST_RESET, ST_RUN, ST_STBY_WAIT_LOW, ST_STBY_OFF, ST_STBY_WAIT_HIGH} state_type;

    logic por_s1_r, por_s2_r, sg_s1_r, sg_s2_r;
    logic pin_req;
    state_type state_r, state_nxt;
    reset_kind_type kind_r, kind_nxt;
    logic [SEQ_CNT_W-1:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic stby_n_r, stby_n_nxt;
    logic ready_r, ready_nxt;
    logic por_evt, dest_evt, func_evt, sg_fail;

    ////////////////////////////////////////////////////////////////////
    // Pin filter for the external reset request
    reset_pin_filter u_pin_filter (
        .clk(clk),
        .rst(rst),
        .reset_pin_n(reset_pin_n),
        .reset_req(pin_req)
    );

    // Synchronisers for PMIC inputs
    always_ff @(posedge clk) begin
        if (rst) begin
            por_s1_r <= 1'b0;
            por_s2_r <= 1'b0;
            sg_s1_r <= 1'b0;
            sg_s2_r <= 1'b0;
        end else begin
            por_s1_r <= power_on_reset_n;
            por_s2_r <= por_s1_r;
            sg_s1_r <= supply_good_in;
            sg_s2_r <= sg_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event decode; supply-good loss outside standby counts as power-on
    always_comb begin
        // Running or in a reset sequence both count as outside standby
        sg_fail = !sg_s2_r && por_s2_r && (state_r == ST_RUN || state_r == ST_RESET);
        por_evt = !por_s2_r || sg_fail;
        dest_evt = destructive_reset_req || pin_req;
        func_evt = functional_reset_req;
    end

    // Length of a sequence kind
    function automatic logic [SEQ_CNT_W-1:0] seq_len(input reset_kind_type k);
        unique case (k)
            REQ_POWER_ON: seq_len = SEQ_CNT_W'(POR_CYCLES);
            REQ_DESTRUCTIVE: seq_len = SEQ_CNT_W'(DR_CYCLES);
            default: seq_len = SEQ_CNT_W'(FR_CYCLES);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Sequence and standby state machine
    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        stby_n_nxt = stby_n_r;
        ready_nxt = ready_r;
        if (por_evt && !(state_r == ST_RESET && kind_r == REQ_POWER_ON && !por_s2_r)) begin
            // Power-on restarts from its first step
            state_nxt = ST_RESET;
            kind_nxt = REQ_POWER_ON;
            cnt_nxt = seq_len(REQ_POWER_ON);
            stby_n_nxt = 1'b1;
            ready_nxt = 1'b0;
        end else if (!por_s2_r) begin
            // Hold at start while the PMIC holds power-on reset
            cnt_nxt = seq_len(REQ_POWER_ON);
        end else if (dest_evt && kind_r != REQ_POWER_ON) begin
            state_nxt = ST_RESET;
            kind_nxt = REQ_DESTRUCTIVE;
            cnt_nxt = seq_len(REQ_DESTRUCTIVE);
            stby_n_nxt = 1'b1;
            ready_nxt = 1'b0;
        end else if (func_evt && state_r != ST_RESET) begin
            state_nxt = ST_RESET;
            kind_nxt = REQ_FUNCTIONAL;
            cnt_nxt = seq_len(REQ_FUNCTIONAL);
            // Leaving standby through a reset powers the domains back up
            stby_n_nxt = 1'b1;
            ready_nxt = 1'b0;
        end else begin
            unique case (state_r)
                ST_RESET: begin
                    if (cnt_r <= SEQ_ONE) begin
                        state_nxt = ST_RUN;
                        kind_nxt = REQ_NONE;
                        done_nxt = 1'b1;
                        ready_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - SEQ_ONE;
                    end
                end
                ST_RUN: begin
                    if (standby_enter) begin
                        state_nxt = ST_STBY_WAIT_LOW;
                        stby_n_nxt = 1'b0;
                        ready_nxt = 1'b0;
                    end
                end
                ST_STBY_WAIT_LOW: begin
                    if (!sg_s2_r) begin
                        state_nxt = ST_STBY_OFF;
                    end
                end
                ST_STBY_OFF: begin
                    if (standby_exit) begin
                        state_nxt = ST_STBY_WAIT_HIGH;
                        stby_n_nxt = 1'b1;
                    end
                end
                ST_STBY_WAIT_HIGH: begin
                    if (sg_s2_r) begin
                        state_nxt = ST_RUN;
                        ready_nxt = 1'b1;
                    end
                end
            endcase
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_RESET;
            kind_r <= REQ_POWER_ON;
            cnt_r <= SEQ_CNT_W'(POR_CYCLES);
            done_r <= 1'b0;
            stby_n_r <= 1'b1;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            stby_n_r <= stby_n_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign in_reset = (state_r == ST_RESET);
    assign reset_kind = kind_r;
    assign reset_done = done_r;
    assign standby_power_request_n = stby_n_r;
    assign standby_domains_ready = ready_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence por_start_s;
        $rose(in_reset) && kind_r == REQ_POWER_ON;
    endsequence

    por_restart_a: assert property (@(posedge clk) disable iff (rst)
        por_evt && !(state_r == ST_RESET && kind_r == REQ_POWER_ON) |=>
        kind_r == REQ_POWER_ON && cnt_r == SEQ_CNT_W'(POR_CYCLES))
        else $error("power-on did not restart sequence");
    dest_restart_a: assert property (@(posedge clk) disable iff (rst)
        por_s2_r && !por_evt && dest_evt && kind_r != REQ_POWER_ON |=>
        kind_r == REQ_DESTRUCTIVE && cnt_r == SEQ_CNT_W'(DR_CYCLES))
        else $error("destructive did not restart sequence");
    func_length_a: assert property (@(posedge clk) disable iff (rst)
        in_reset && kind_r == REQ_FUNCTIONAL |-> cnt_r <= SEQ_CNT_W'(FR_CYCLES))
        else $error("functional sequence too long");
    dest_length_a: assert property (@(posedge clk) disable iff (rst)
        in_reset && kind_r == REQ_DESTRUCTIVE |-> cnt_r <= SEQ_CNT_W'(DR_CYCLES))
        else $error("destructive sequence too long");
    por_length_a: assert property (@(posedge clk) disable iff (rst)
        in_reset && kind_r == REQ_POWER_ON |-> cnt_r <= SEQ_CNT_W'(POR_CYCLES))
        else $error("power-on sequence too long");
    stby_request_a: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_RUN && standby_enter && !por_evt && !dest_evt && !func_evt |=>
        !standby_power_request_n)
        else $error("standby request not asserted");
    sg_drop_por_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == ST_RUN || state_r == ST_RESET) && por_s2_r && !sg_s2_r |=>
        in_reset && kind_r == REQ_POWER_ON)
        else $error("supply-good loss ignored");
    exit_ready_a: assert property (@(posedge clk) disable iff (rst)
        $rose(standby_domains_ready) |-> $past(sg_s2_r) && standby_power_request_n)
        else $error("domains ready before supply-good");
    done_once_a: assert property (@(posedge clk) disable iff (rst)
        reset_done |-> !in_reset ##1 !reset_done)
        else $error("done pulse malformed");
endmodule : reset_standby_ctrl
`default_nettype wire

// File: rst_seq_pkg.sv
// Purpose: Shared constants and types for the reset and standby sequencer
// Assumes: 40 MHz system clock (25 ns period)
// Notes: Times are kept in their own units; cycle counts are derived here
package rst_seq_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // Maximum sequence durations in microseconds
    localparam int FUNCTIONAL_RESET_TIME_US = 545;
    localparam int DESTRUCTIVE_RESET_TIME_US = 1370;
    localparam int POWER_ON_RESET_TIME_US = 1500;
    // Longest times round down to whole cycles
    localparam int FR_CYCLES = (FUNCTIONAL_RESET_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int DR_CYCLES = (DESTRUCTIVE_RESET_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int POR_CYCLES = (POWER_ON_RESET_TIME_US * 1000) / CLK_PERIOD_NS;
    // External reset pin pulse widths in ns
    localparam int RESET_GLITCH_REJECT_WIDTH_NS = 17;
    localparam int RESET_PULSE_ACCEPT_WIDTH_NS = 400;
    // Accept after a low run longer than the reject width, rounded up
    localparam int PIN_ACCEPT_CYCLES =
        (RESET_GLITCH_REJECT_WIDTH_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS + 1;
    // Supply-good minimum pulse widths in microseconds
    localparam int SUPPLY_GOOD_MIN_LOW_TIME_US = 36;
    localparam int SUPPLY_GOOD_MIN_HIGH_TIME_US = 36;
    localparam int SEQ_CNT_W = 17;
    localparam int PIN_CNT_W = 4;
    localparam logic [SEQ_CNT_W-1:0] SEQ_ONE = 17'h00001;
    localparam logic [PIN_CNT_W-1:0] PIN_ONE = 4'h1;

    typedef enum logic [1:0] {
        REQ_NONE,
        REQ_FUNCTIONAL,
        REQ_DESTRUCTIVE,
        REQ_POWER_ON
    } reset_kind_type;
endpackage : rst_seq_pkg

// File: reset_pin_filter.sv
// Purpose: Synchronise and pulse-filter the active-low external reset pin
// Assumes: Pin is asynchronous to clk
// Notes: Short glitches are dropped; a long enough low run yields one request pulse
`default_nettype none
module reset_pin_filter
    import rst_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    output logic reset_req
);
    logic sync1_r, sync2_r, sync1_nxt, sync2_nxt;
    logic [PIN_CNT_W-1:0] low_cnt_r, low_cnt_nxt;
    logic req_r, req_nxt;
    localparam logic [PIN_CNT_W-1:0] ACCEPT = PIN_CNT_W'(PIN_ACCEPT_CYCLES);

    ////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser, then low-run counter
    always_comb begin
        sync1_nxt = reset_pin_n;
        sync2_nxt = sync1_r;
        low_cnt_nxt = low_cnt_r;
        req_nxt = 1'b0;
        if (sync2_r) begin
            low_cnt_nxt = '0;
        end else if (low_cnt_r != ACCEPT) begin
            low_cnt_nxt = low_cnt_r + PIN_ONE;
            req_nxt = (low_cnt_r + PIN_ONE) == ACCEPT;
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            low_cnt_r <= '0;
            req_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            low_cnt_r <= low_cnt_nxt;
            req_r <= req_nxt;
        end
    end

    assign reset_req = req_r;

    // Accepted run must have been low for the accept count
    accept_width_a: assert property (@(posedge clk) disable iff (rst)
        $rose(req_r) |-> $past(low_cnt_r) == ACCEPT - PIN_ONE)
        else $error("reset pin accepted too early");
endmodule : reset_pin_filter
`default_nettype wire

// File: pmic_model.sv
// Purpose: Behavioural power management IC for the reset and standby sequencer
// Assumes: Bench says when the device supplies are in range
// Notes: Domains switch only after a full hold time since the last change
`default_nettype none
module pmic_model #(
    parameter int HOLD_CYCLES = 1500
) (
    input wire logic clk,
    input wire logic supplies_ok,
    input wire logic standby_power_request_n,
    input wire logic sg_drop,
    output logic power_on_reset_n,
    output logic supply_good_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dom_on_r = 1'b1;
    logic req_seen_r = 1'b1;
    int hold_cnt = 0;
    // Reset held low until supplies are good, and on any supply fault
    assign power_on_reset_n = supplies_ok;
    // Supply-good drops with the domains and otherwise follows reset
    // Bench may pull supply-good low alone to provoke a power-on sequence
    assign supply_good_in = supplies_ok & dom_on_r & ~sg_drop;
    // Domains follow the request once the level has been held long enough
    always @(posedge clk) begin
        req_seen_r <= standby_power_request_n;
        if (standby_power_request_n !== req_seen_r) begin
            hold_cnt <= 0;
        end else if (dom_on_r !== req_seen_r && hold_cnt >= HOLD_CYCLES) begin
            dom_on_r <= req_seen_r;
            hold_cnt <= 0;
        end else if (hold_cnt < HOLD_CYCLES) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
endmodule // pmic_model
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the reset and standby sequencer
// Assumes: 40 MHz clock, inputs driven on the falling edge
// Notes: Power-on timing first, then standby walk in a table; glitch, functional timing and restart cases follow
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rst_seq_pkg::*;
    typedef struct {
        logic enter;
        logic leave;
        int wait_n;
        logic exp_req_n;
        logic exp_ready;
    } row_type;
    row_type rows [5] = '{'{1, 0, 4, 0, 0}, '{0, 0, 2000, 0, 0}, '{0, 1, 4, 1, 0},
        '{0, 0, 2000, 1, 1}, '{0, 1, 4, 1, 1}};
    logic clk, rst, reset_pin_n, functional_reset_req, destructive_reset_req;
    logic standby_enter, standby_exit, supplies_ok, power_on_reset_n, supply_good_in;
    logic in_reset, reset_done, standby_power_request_n, standby_domains_ready;
    logic sg_drop;
    reset_kind_type reset_kind;
    int bad_count = 0;
    int check_count = 0;
    int n;
    ////////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    reset_standby_ctrl uut (.clk(clk), .rst(rst), .power_on_reset_n(power_on_reset_n),
        .reset_pin_n(reset_pin_n), .supply_good_in(supply_good_in),
        .functional_reset_req(functional_reset_req),
        .destructive_reset_req(destructive_reset_req), .standby_enter(standby_enter),
        .standby_exit(standby_exit), .in_reset(in_reset), .reset_kind(reset_kind),
        .reset_done(reset_done), .standby_power_request_n(standby_power_request_n),
        .standby_domains_ready(standby_domains_ready));
    pmic_model pmic (.clk(clk), .supplies_ok(supplies_ok), .sg_drop(sg_drop),
        .standby_power_request_n(standby_power_request_n),
        .power_on_reset_n(power_on_reset_n), .supply_good_in(supply_good_in));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Bounded wait for the end-of-sequence pulse
    task automatic wait_done(input int bound, output int cnt);
        cnt = 0;
        while (reset_done !== 1'b1) begin
            @(negedge clk);
            cnt++;
            if (cnt > bound) begin
                chk("done wait", 2'h1, 2'h0);
                close_out();
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        reset_pin_n = 1'b1;
        functional_reset_req = 1'b0;
        destructive_reset_req = 1'b0;
        standby_enter = 1'b0;
        standby_exit = 1'b0;
        supplies_ok = 1'b0;
        sg_drop = 1'b0;
        cyc(8);
        chk("rst in_reset", 2'h1, {1'b0, in_reset});
        chk("rst kind", REQ_POWER_ON, reset_kind);
        chk("rst request_n", 2'h1, {1'b0, standby_power_request_n});
        chk("rst ready", 2'h0, {1'b0, standby_domains_ready});
        rst = 1'b0;
        cyc(20);
        supplies_ok = 1'b1;
        wait_done(POR_CYCLES + 50, n);
        chk("por time", 2'h1, {1'b0, n >= POR_CYCLES - 2 && n <= POR_CYCLES + 8});
        cyc(2);
        chk("run in_reset", 2'h0, {1'b0, in_reset});
        $display("test power-on sequence done");
        // Standby entry and exit walk
        foreach (rows[i]) begin
            standby_enter = rows[i].enter;
            standby_exit = rows[i].leave;
            cyc(1);
            standby_enter = 1'b0;
            standby_exit = 1'b0;
            cyc(rows[i].wait_n);
            chk("request_n", {1'b0, rows[i].exp_req_n}, {1'b0, standby_power_request_n});
            chk("ready", {1'b0, rows[i].exp_ready}, {1'b0, standby_domains_ready});
        end
        $display("test standby walk done");
        // One-cycle pin glitch must not reset
        reset_pin_n = 1'b0;
        cyc(1);
        reset_pin_n = 1'b1;
        cyc(10);
        chk("glitch in_reset", 2'h0, {1'b0, in_reset});
        $display("test pin glitch done");
        // Functional sequence, repeat request refused while running
        functional_reset_req = 1'b1;
        cyc(1);
        functional_reset_req = 1'b0;
        cyc(3);
        chk("fr kind", REQ_FUNCTIONAL, reset_kind);
        cyc(100);
        functional_reset_req = 1'b1;
        cyc(1);
        functional_reset_req = 1'b0;
        wait_done(FR_CYCLES, n);
        n = n + 105;
        chk("fr time", 2'h1, {1'b0, n >= FR_CYCLES - 2 && n <= FR_CYCLES + 4});
        $display("test functional sequence done");
        // Long pin pulse, then destructive and power-on resets take over
        cyc(3);
        reset_pin_n = 1'b0;
        cyc(20);
        reset_pin_n = 1'b1;
        cyc(5);
        chk("pin in_reset", 2'h1, {1'b0, in_reset});
        destructive_reset_req = 1'b1;
        cyc(1);
        destructive_reset_req = 1'b0;
        cyc(3);
        chk("dr kind", REQ_DESTRUCTIVE, reset_kind);
        // Supply-good lost alone while power-on reset stays released
        sg_drop = 1'b1;
        cyc(10);
        chk("sg drop kind", REQ_POWER_ON, reset_kind);
        chk("sg drop in_reset", 2'h1, {1'b0, in_reset});
        sg_drop = 1'b0;
        cyc(5);
        supplies_ok = 1'b0;
        cyc(300);
        supplies_ok = 1'b1;
        cyc(5);
        chk("por kind", REQ_POWER_ON, reset_kind);
        chk("por in_reset", 2'h1, {1'b0, in_reset});
        $display("test restart chain done");
        close_out();
    end
endmodule // tb
`default_nettype wire
